// ---- hdl/mca_pkg.sv ----
package mca_pkg;

  // ==========================================================================
  // Register map
  localparam logic [3:0] MCA_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] MCA_ADDR_X_START = 4'h1;
  localparam logic [3:0] MCA_ADDR_X_END   = 4'h2;
  localparam logic [3:0] MCA_ADDR_Y_START = 4'h3;
  localparam logic [3:0] MCA_ADDR_Y_END   = 4'h4;
  localparam logic [3:0] MCA_ADDR_STATUS  = 4'h5;

  // ==========================================================================
  // Control fields
  localparam int         MCA_X_SEL_LSB     = 0;
  localparam int         MCA_Y_SEL_LSB     = 4;
  localparam int         MCA_Y_EN_BIT      = 14;
  localparam int         MCA_X_EN_BIT      = 15;
  localparam logic [3:0] MCA_SEL_NONE      = 4'hF;
  localparam logic [15:0] MCA_CONTROL_RESET = 16'h00FF;
  localparam logic [15:0] MCA_CONTROL_MASK  = 16'hC0FF;
  localparam logic [15:0] MCA_ADDR_RESET    = 16'h0000;
  localparam logic [15:0] MCA_WORD_MASK     = 16'hFFFE;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic [3:0]  reg_sel;
    logic        dir_down;
    logic [15:0] next_ea;
  } mca_req_type;

  typedef struct packed {
    logic        wrapped;
    logic [15:0] ea;
  } mca_rsp_type;

  typedef enum logic [1:0] {
    MCA_PASS      = 2'b00,
    MCA_WRAP_UP   = 2'b01,
    MCA_WRAP_DOWN = 2'b10
  } mca_action_type;

endpackage

// ---- hdl/mca_bound.sv ----
module mca_bound
  import mca_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        active,
  input  wire logic [3:0]  sel,
  input  wire logic        word_only,
  input  wire logic [15:0] start_addr,
  input  wire logic [15:0] end_addr,
  input  wire mca_req_type req,
  output mca_rsp_type      rsp
);

  mca_action_type action;
  logic [15:0]    ea_in;

  always_comb
  begin
    ea_in = word_only ? (req.next_ea & MCA_WORD_MASK) : req.next_ea;
    action = MCA_PASS;
    if (active && req.valid && req.reg_sel == sel)
    begin
      if (!req.dir_down && ea_in > end_addr)
        action = MCA_WRAP_UP;
      else if (req.dir_down && ea_in < start_addr)
        action = MCA_WRAP_DOWN;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      rsp <= '0;
    else
    begin
      unique case (action)
        MCA_WRAP_UP:   rsp <= {1'b1, start_addr};
        MCA_WRAP_DOWN: rsp <= {1'b1, word_only ? (end_addr & MCA_WORD_MASK) : end_addr};
        MCA_PASS:      rsp <= {1'b0, req.next_ea};
        default:       rsp <= {1'b0, req.next_ea};
      endcase
    end
  end

endmodule

// ---- hdl/mca_regs.sv ----
module mca_regs
  import mca_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [1:0]  wrap_flags,
  output logic [15:0]      rdata,
  output logic [15:0]      modulo_control,
  output logic [15:0]      x_buffer_start,
  output logic [15:0]      x_buffer_end,
  output logic [15:0]      y_buffer_start,
  output logic [15:0]      y_buffer_end
);

  logic [1:0] wrap_seen;

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      modulo_control <= MCA_CONTROL_RESET;
      x_buffer_start <= MCA_ADDR_RESET;
      x_buffer_end   <= MCA_ADDR_RESET;
      y_buffer_start <= MCA_ADDR_RESET;
      y_buffer_end   <= MCA_ADDR_RESET;
    end
    else if (wr)
    begin
      unique case (addr)
        MCA_ADDR_CONTROL: modulo_control <= wdata & MCA_CONTROL_MASK;
        MCA_ADDR_X_START: x_buffer_start <= wdata;
        MCA_ADDR_X_END:   x_buffer_end   <= wdata;
        MCA_ADDR_Y_START: y_buffer_start <= wdata;
        MCA_ADDR_Y_END:   y_buffer_end   <= wdata;
        default:          ;
      endcase
    end
  end

  // Sticky wrap seen flags, set wins over read clear
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      wrap_seen <= 2'b00;
    else if (rd && addr == MCA_ADDR_STATUS)
      wrap_seen <= wrap_flags;
    else
      wrap_seen <= wrap_seen | wrap_flags;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      rdata <= 16'h0000;
    else if (rd)
    begin
      unique case (addr)
        MCA_ADDR_CONTROL: rdata <= modulo_control;
        MCA_ADDR_X_START: rdata <= x_buffer_start;
        MCA_ADDR_X_END:   rdata <= x_buffer_end;
        MCA_ADDR_Y_START: rdata <= y_buffer_start;
        MCA_ADDR_Y_END:   rdata <= y_buffer_end;
        MCA_ADDR_STATUS:  rdata <= {14'h0000, wrap_seen};
        default:          rdata <= 16'h0000;
      endcase
    end
  end

endmodule

// ---- hdl/mca_top.sv ----
module mca_top
  import mca_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  input  wire mca_req_type x_read_req,
  input  wire mca_req_type x_write_req,
  input  wire mca_req_type y_req,
  output mca_rsp_type      x_read_rsp,
  output mca_rsp_type      x_write_rsp,
  output mca_rsp_type      y_rsp
);

  logic [15:0] modulo_control;
  logic [15:0] x_buffer_start;
  logic [15:0] x_buffer_end;
  logic [15:0] y_buffer_start;
  logic [15:0] y_buffer_end;
  logic [3:0]  x_pointer_select;
  logic [3:0]  y_pointer_select;
  logic        x_circular_enable;
  logic        y_circular_enable;
  logic        x_active;
  logic        y_active;

  // ==========================================================================
  // Registers
  mca_regs u_regs (
    .mclk           (mclk),
    .rst_b          (rst_b),
    .addr           (addr),
    .wdata          (wdata),
    .wr             (wr),
    .rd             (rd),
    .wrap_flags     ({y_rsp.wrapped, x_read_rsp.wrapped | x_write_rsp.wrapped}),
    .rdata          (rdata),
    .modulo_control (modulo_control),
    .x_buffer_start (x_buffer_start),
    .x_buffer_end   (x_buffer_end),
    .y_buffer_start (y_buffer_start),
    .y_buffer_end   (y_buffer_end)
  );

  // ==========================================================================
  // Mode decode
  assign x_pointer_select  = modulo_control[MCA_X_SEL_LSB +: 4];
  assign y_pointer_select  = modulo_control[MCA_Y_SEL_LSB +: 4];
  assign x_circular_enable = modulo_control[MCA_X_EN_BIT];
  assign y_circular_enable = modulo_control[MCA_Y_EN_BIT];
  assign x_active = x_circular_enable && x_pointer_select != MCA_SEL_NONE;
  assign y_active = y_circular_enable && y_pointer_select != MCA_SEL_NONE;

  // ==========================================================================
  // Address generators: one window per space, shared by X read and write
  mca_bound u_x_read (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .active     (x_active),
    .sel        (x_pointer_select),
    .word_only  (1'b0),
    .start_addr (x_buffer_start),
    .end_addr   (x_buffer_end),
    .req        (x_read_req),
    .rsp        (x_read_rsp)
  );

  mca_bound u_x_write (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .active     (x_active),
    .sel        (x_pointer_select),
    .word_only  (1'b0),
    .start_addr (x_buffer_start),
    .end_addr   (x_buffer_end),
    .req        (x_write_req),
    .rsp        (x_write_rsp)
  );

  mca_bound u_y (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .active     (y_active),
    .sel        (y_pointer_select),
    .word_only  (1'b1),
    .start_addr (y_buffer_start),
    .end_addr   (y_buffer_end),
    .req        (y_req),
    .rsp        (y_rsp)
  );

  // ==========================================================================
  // Checks
  AST_X_DISABLED_PASS: assert property (@(posedge mclk) disable iff (!rst_b)
    (!x_active && x_read_req.valid) |=> (x_read_rsp.ea == $past(x_read_req.next_ea) && !x_read_rsp.wrapped))
    else $error("X read altered while disabled");
  AST_X_WRAP_UP: assert property (@(posedge mclk) disable iff (!rst_b)
    (x_active && x_read_req.valid && x_read_req.reg_sel == x_pointer_select && !x_read_req.dir_down
     && x_read_req.next_ea > x_buffer_end && !wr) |=> (x_read_rsp.ea == x_buffer_start))
    else $error("X overrun not reloaded with start");
  AST_X_WRAP_DOWN: assert property (@(posedge mclk) disable iff (!rst_b)
    (x_active && x_write_req.valid && x_write_req.reg_sel == x_pointer_select && x_write_req.dir_down
     && x_write_req.next_ea < x_buffer_start && !wr) |=> (x_write_rsp.ea == x_buffer_end))
    else $error("X underrun not reloaded with end");
  AST_X_OTHER_REG: assert property (@(posedge mclk) disable iff (!rst_b)
    (x_write_req.valid && x_write_req.reg_sel != x_pointer_select) |=> !x_write_rsp.wrapped)
    else $error("Unselected register was wrapped");
  AST_Y_WORD: assert property (@(posedge mclk) disable iff (!rst_b)
    y_rsp.wrapped |-> !y_rsp.ea[0] || y_rsp.ea == y_buffer_start)
    else $error("Y wrap not word aligned");
  AST_Y_DISABLED: assert property (@(posedge mclk) disable iff (!rst_b)
    (!y_active && y_req.valid) |=> !y_rsp.wrapped)
    else $error("Y wrapped while disabled");
  AST_X_ENABLE: assert property (@(posedge mclk) disable iff (!rst_b)
    x_active |-> (modulo_control[MCA_X_EN_BIT] && modulo_control[3:0] != MCA_SEL_NONE))
    else $error("X active without enable");
  AST_REG_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr && addr == MCA_ADDR_Y_END) |=> (y_buffer_end == $past(wdata)))
    else $error("Y end register not loaded");

endmodule

// ---- tb/mca_agu.sv ----
module mca_agu
  import mca_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        load,
  input  wire logic        go,
  input  wire logic        down,
  input  wire logic [3:0]  sel,
  input  wire logic [15:0] init,
  input  wire mca_rsp_type rsp,
  output mca_req_type      req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] ptr;
  logic        pend;
  // Word step from the current pointer
  assign req = '{go, sel, down, down ? ptr - 16'h0002 : ptr + 16'h0002};
  // Pointer follows the corrected address
  always_ff @(posedge mclk)
  begin
    pend <= go;
    if (load)
      ptr <= init;
    else if (pend)
      ptr <= rsp.ea;
  end
endmodule

// ---- tb/tb.sv ----
module tb;
  import mca_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 0;
  logic        rst_b = 0;
  logic        wr = 0;
  logic        rd = 0;
  logic        load = 0;
  logic        go = 0;
  logic        down = 0;
  logic [3:0]  addr = 0;
  logic [3:0]  sel = 4'hF;
  logic [15:0] wdata = 0;
  logic [15:0] init = 0;
  logic [15:0] rdata;
  mca_req_type xr_req;
  mca_req_type xw_req = '0;
  mca_req_type y_req = '0;
  mca_rsp_type xr_rsp;
  mca_rsp_type xw_rsp;
  mca_rsp_type y_rsp;
  int          n_mismatch = 0;
  int          compares = 0;

  always #25 mclk = ~mclk;

  mca_top mca_top_inst (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .x_read_req(xr_req), .x_write_req(xw_req), .y_req(y_req),
    .x_read_rsp(xr_rsp), .x_write_rsp(xw_rsp), .y_rsp(y_rsp));
  mca_agu mca_agu_inst (.mclk(mclk), .load(load), .go(go), .down(down), .sel(sel), .init(init),
    .rsp(xr_rsp), .req(xr_req));

  // ==========================================
  // Helpers
  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk("rdata", {1'b0, e}, {1'b0, rdata});
  endtask

  task automatic dreq(input bit y, input logic [3:0] s, input logic dn, input logic [15:0] ea,
    input logic [16:0] e);
    @(posedge mclk);
    if (y)
      y_req <= '{1'b1, s, dn, ea};
    else
      xw_req <= '{1'b1, s, dn, ea};
    @(posedge mclk);
    y_req.valid <= 1'b0;
    xw_req.valid <= 1'b0;
    #1 chk(y ? "y_rsp" : "xw_rsp", e, y ? y_rsp : xw_rsp);
  endtask

  task automatic xstep(input logic dn, input logic [16:0] e);
    @(posedge mclk);
    down <= dn;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    #1 chk("xr_rsp", e, xr_rsp);
  endtask

  task automatic conclude;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset;
    rreg(4'h0, 16'h00FF);
    rreg(4'h1, 16'h0000);
    rreg(4'h6, 16'h0000);
  endtask

  task automatic t_regs;
    wreg(4'h1, 16'h1000);
    wreg(4'h2, 16'h101F);
    wreg(4'h3, 16'h2000);
    wreg(4'h4, 16'h203F);
    wreg(4'h6, 16'h5555);
    rreg(4'h2, 16'h101F);
    rreg(4'h3, 16'h2000);
    wreg(4'h0, 16'hFFFF);
    rreg(4'h0, 16'hC0FF);
    dreq(0, 4'hF, 0, 16'h1020, {1'b0, 16'h1020});
    dreq(1, 4'hF, 0, 16'h2040, {1'b0, 16'h2040});
  endtask

  task automatic t_x;
    wreg(4'h0, 16'h8003);
    @(posedge mclk);
    sel <= 4'h3;
    init <= 16'h101E;
    load <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
    xstep(0, {1'b1, 16'h1000});
    xstep(1, {1'b1, 16'h101F});
    xstep(1, {1'b0, 16'h101D});
    dreq(0, 4'h3, 0, 16'h1020, {1'b1, 16'h1000});
    dreq(0, 4'h3, 1, 16'h0FFE, {1'b1, 16'h101F});
    dreq(0, 4'h4, 0, 16'h1020, {1'b0, 16'h1020});
    wreg(4'h0, 16'h0003);
    dreq(0, 4'h3, 0, 16'h1020, {1'b0, 16'h1020});
  endtask

  task automatic t_y;
    wreg(4'h0, 16'h405F);
    dreq(1, 4'h5, 0, 16'h2041, {1'b1, 16'h2000});
    dreq(1, 4'h5, 1, 16'h1FFF, {1'b1, 16'h203E});
    dreq(1, 4'h5, 0, 16'h2010, {1'b0, 16'h2010});
    rreg(4'h5, 16'h0003);
    rreg(4'h5, 16'h0000);
  endtask

  task automatic t_rerst;
    dreq(1, 4'h5, 0, 16'h2041, {1'b1, 16'h2000});
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rreg(4'h0, 16'h00FF);
    rreg(4'h4, 16'h0000);
    rreg(4'h5, 16'h0000);
    dreq(1, 4'h5, 0, 16'h2041, {1'b0, 16'h2041});
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_x();
    t_y();
    t_rerst();
    conclude();
  end

  initial
  begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule
